//--- hdl/counter_array_pkg.sv
/*
  Shared constants for the counter array: register addresses, field positions,
  reset values, divider ratios and the mode decode used by each module.
  Assumes a single 8-bit register port clocked by the system clock.
*/
package counter_array_pkg;

  // ----------------------------------------------------------------------
  // Register addresses
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'hD8;
  localparam logic [7:0] ADDR_MODE = 8'hD9;
  localparam logic [7:0] ADDR_CPM_BASE = 8'hDA;
  localparam logic [7:0] ADDR_CPL_BASE = 8'hE0;
  localparam logic [7:0] ADDR_CNT_L = 8'hE8;
  localparam logic [7:0] ADDR_CPH_BASE = 8'hF0;
  localparam logic [7:0] ADDR_CNT_H = 8'hF8;
  localparam int NUM_MODULES = 6;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int CTRL_OVF_BIT = 7;
  localparam int CTRL_RUN_BIT = 6;
  localparam int MODE_IDLE_BIT = 7;
  localparam int MODE_SEL_LSB = 1;
  localparam int MODE_OVF_IE_BIT = 0;
  localparam int CPM_WIDE_BIT = 7;
  localparam int CPM_ECOM_BIT = 6;
  localparam int CPM_RISE_BIT = 5;
  localparam int CPM_FALL_BIT = 4;
  localparam int CPM_MAT_BIT = 3;
  localparam int CPM_TOG_BIT = 2;
  localparam int CPM_PWM_BIT = 1;
  localparam int CPM_IE_BIT = 0;

  // ----------------------------------------------------------------------
  // Reset values and divider ratios
  // ----------------------------------------------------------------------
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [7:0] CPM_RESET = 8'h00;
  localparam logic [15:0] CNT_RESET = 16'h0000;
  localparam logic [15:0] CP_RESET = 16'h0000;
  localparam int DIV_SLOW = 12;
  localparam int DIV_FAST = 4;
  localparam int DIV_OSC = 8;

  typedef enum logic [2:0] {
    TB_DIV12 = 3'b000,
    TB_DIV4 = 3'b001,
    TB_TIMER0 = 3'b010,
    TB_COUNT_IN = 3'b011,
    TB_SYSCLK = 3'b100,
    TB_OSC8 = 3'b101
  } timebase_t;

  typedef enum logic [2:0] {
    MODE_OFF = 3'b000,
    MODE_CAPTURE = 3'b001,
    MODE_TIMER = 3'b010,
    MODE_FAST_OUT = 3'b011,
    MODE_FREQ = 3'b100,
    MODE_PWM8 = 3'b101,
    MODE_PWM16 = 3'b110
  } cc_mode_t;

  function automatic cc_mode_t mode_of(input logic [7:0] cpm);
    cc_mode_t m;
    m = MODE_OFF;
    if (cpm[CPM_PWM_BIT]) begin
      if (cpm[CPM_TOG_BIT]) m = MODE_FREQ;
      else if (cpm[CPM_WIDE_BIT]) m = MODE_PWM16;
      else m = MODE_PWM8;
    end else if (cpm[CPM_MAT_BIT]) begin
      m = cpm[CPM_TOG_BIT] ? MODE_FAST_OUT : MODE_TIMER;
    end else if (!cpm[CPM_TOG_BIT] && (cpm[CPM_RISE_BIT] || cpm[CPM_FALL_BIT])) begin
      m = MODE_CAPTURE;
    end
    return m;
  endfunction

endpackage

//--- hdl/counter_timebase.sv
/*
  Timebase selector: produces a one-cycle tick for each counter increment.
  Assumes count_in_s and osc_s are already synchronised to core_clk.
*/
`timescale 1ns/1ps
module counter_timebase (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Sources
  input wire logic [2:0] sel,
  input wire logic timer0_ovf,
  input wire logic count_in_s,
  input wire logic osc_s,
  // Result
  output logic tick
);

  logic [3:0] slow_q;
  logic [1:0] fast_q;
  logic [2:0] osc_cnt_q;
  logic count_in_prev_q;
  logic osc_prev_q;

  // ----------------------------------------------------------------------
  // Free-running prescalers
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (reset || slow_q == 4'(counter_array_pkg::DIV_SLOW - 1)) slow_q <= 4'h0;
    else slow_q <= slow_q + 4'h1;
  end

  always_ff @(posedge core_clk) begin
    if (reset) fast_q <= 2'h0;
    else fast_q <= fast_q + 2'h1;
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      count_in_prev_q <= 1'b0;
      osc_prev_q <= 1'b0;
      osc_cnt_q <= 3'h0;
    end else begin
      count_in_prev_q <= count_in_s;
      osc_prev_q <= osc_s;
      if (osc_s && !osc_prev_q) osc_cnt_q <= osc_cnt_q + 3'h1;
    end
  end

  // The oscillator must not outrun core_clk or rising edges are missed.
  always_comb begin
    case (counter_array_pkg::timebase_t'(sel)) // [R4]
      counter_array_pkg::TB_DIV12: tick = slow_q == 4'(counter_array_pkg::DIV_SLOW - 1);
      counter_array_pkg::TB_DIV4: tick = fast_q == 2'(counter_array_pkg::DIV_FAST - 1);
      counter_array_pkg::TB_TIMER0: tick = timer0_ovf;
      counter_array_pkg::TB_COUNT_IN: tick = count_in_prev_q && !count_in_s; // [R5]
      counter_array_pkg::TB_SYSCLK: tick = 1'b1;
      counter_array_pkg::TB_OSC8: tick = osc_s && !osc_prev_q && // [R6]
                                         osc_cnt_q == 3'(counter_array_pkg::DIV_OSC - 1);
      default: tick = 1'b0;
    endcase
  end

endmodule

//--- hdl/capture_compare_unit.sv
/*
  One capture/compare module: mode register, 16-bit compare register and line.
  Assumes eval pulses follow each counter advance by one cycle and that
  line_s is already synchronised.
*/
`timescale 1ns/1ps
module capture_compare_unit (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Register writes
  input wire logic mode_wr,
  input wire logic low_wr,
  input wire logic high_wr,
  input wire logic [7:0] wdata,
  // Counter view
  input wire logic [15:0] cnt,
  input wire logic eval,
  input wire logic wrap,
  input wire logic low_wrap,
  input wire logic line_s,
  // Results
  output logic [7:0] cpm_q,
  output logic [15:0] cp_q,
  output logic flag_set,
  output logic line_out_q,
  output logic line_oe
);

  counter_array_pkg::cc_mode_t mode;
  logic line_prev_q;
  logic ecom;
  logic rise;
  logic fall;
  logic full_hit;
  logic low_hit;

  assign mode = counter_array_pkg::mode_of(cpm_q);
  assign ecom = cpm_q[counter_array_pkg::CPM_ECOM_BIT];
  assign rise = line_s && !line_prev_q;
  assign fall = !line_s && line_prev_q;
  assign full_hit = eval && ecom && cnt == cp_q; // [R27]
  assign low_hit = eval && ecom && cnt[7:0] == cp_q[7:0];
  assign line_oe = ecom && (cpm_q[counter_array_pkg::CPM_TOG_BIT] ||
                            cpm_q[counter_array_pkg::CPM_PWM_BIT]);

  always_comb begin
    case (mode) // [R12] [R21]
      counter_array_pkg::MODE_CAPTURE: flag_set = // [R13]
        (rise && cpm_q[counter_array_pkg::CPM_RISE_BIT]) ||
        (fall && cpm_q[counter_array_pkg::CPM_FALL_BIT]);
      counter_array_pkg::MODE_TIMER, counter_array_pkg::MODE_FAST_OUT,
      counter_array_pkg::MODE_PWM16: flag_set = full_hit; // [R15]
      counter_array_pkg::MODE_PWM8, counter_array_pkg::MODE_FREQ: flag_set = low_hit;
      default: flag_set = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (reset) line_prev_q <= 1'b0;
    else line_prev_q <= line_s;
  end

  // ----------------------------------------------------------------------
  // Mode register; compare byte writes steer the compare-enable bit
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (reset) cpm_q <= counter_array_pkg::CPM_RESET;
    else if (mode_wr) cpm_q <= wdata;
    else if (low_wr) cpm_q[counter_array_pkg::CPM_ECOM_BIT] <= 1'b0; // [R16] [R17]
    else if (high_wr) cpm_q[counter_array_pkg::CPM_ECOM_BIT] <= 1'b1; // [R16]
  end

  // Software writes beat a same-cycle capture or reload.
  always_ff @(posedge core_clk) begin
    if (reset) cp_q <= counter_array_pkg::CP_RESET;
    else if (low_wr) cp_q[7:0] <= wdata;
    else if (high_wr) cp_q[15:8] <= wdata;
    else if (mode == counter_array_pkg::MODE_CAPTURE && flag_set) cp_q <= cnt; // [R13]
    else if (mode == counter_array_pkg::MODE_FREQ && low_hit)
      cp_q[7:0] <= cp_q[7:0] + cp_q[15:8]; // [R19] [R20]
    else if (mode == counter_array_pkg::MODE_PWM8 && low_wrap) cp_q[7:0] <= cp_q[15:8]; // [R24]
  end

  // A match in the same step as a wrap wins, so a zero compare gives full duty.
  always_ff @(posedge core_clk) begin
    if (reset) line_out_q <= 1'b0;
    else begin
      case (mode)
        counter_array_pkg::MODE_FAST_OUT: if (full_hit) line_out_q <= !line_out_q; // [R18]
        counter_array_pkg::MODE_FREQ: if (low_hit) line_out_q <= !line_out_q; // [R19]
        counter_array_pkg::MODE_PWM8: begin
          if (low_hit) line_out_q <= 1'b1; // [R24]
          else if (low_wrap) line_out_q <= 1'b0;
        end
        counter_array_pkg::MODE_PWM16: begin
          if (full_hit) line_out_q <= 1'b1; // [R25]
          else if (wrap) line_out_q <= 1'b0;
        end
        default: line_out_q <= line_out_q;
      endcase
    end
  end

endmodule

//--- hdl/counter_array.sv
/*
  Programmable counter array: a 16-bit counter with selectable timebase and
  six capture/compare modules, reached through an 8-bit register port.
  Assumes a single 50 MHz core_clk, a synchronous active-high reset, and that
  timer0_ovf, cpu_idle and the enable inputs come from core_clk logic.
*/
// Behaviour
// [R1]: Six independent 16-bit capture/compare modules share one 16-bit counter, each own line.
// [R2]: Low-byte read snapshots high byte; next high-byte read returns the snapshot.
// [R3]: Counter reads never disturb counting.
// [R4]: Timebase select picks clk/12, clk/4, timer-0, count input falls, clk, osc/8.
// [R5]: External count input holds each level two clocks; counts at most clk/4.
// [R6]: Oscillator/8 source is synchronised; oscillator no faster than system clock.
// [R7]: Wrap from FFFF to 0000 sets overflow flag; interrupt if enabled.
// [R8]: Hardware only sets overflow and module flags; software clears by writing zero.
// [R9]: Interrupt reaches processor only with global and block enables set.
// [R10]: Idle with idle-control clear keeps everything running.
// [R11]: Module interrupt enable masks module flag onto request without touching flag.
// [R12]: Rising, falling or both capture bits pick capture edge.
// [R13]: Captured edge copies counter into compare register and sets module flag.
// [R14]: Capture line holds each level two clocks before an edge counts.
// [R15]: Timer mode sets module flag when counter equals compare register.
// [R16]: Low compare write clears compare enable; high compare write sets it.
// [R17]: Software writes low compare byte before high byte.
// [R18]: Fast output mode inverts line on every full match.
// [R19]: Frequency mode low-byte match toggles line and adds high byte to low.
// [R20]: Frequency mode high byte zero means 256 timebase clocks.
// [R21]: Compare enable plus pwm picks 8-bit, plus wide bit picks 16-bit PWM.
// [R22]: Run bit set counts; cleared holds counter value.
// [R23]: Idle-control set suspends counter and modules while processor idles; capture-mode modules still capture and set flags.
// [R24]: 8-bit PWM: low match drives high, low wrap drives low and reloads.
// [R25]: 16-bit PWM: full match drives high, counter wrap drives low.
// [R26]: Module lines and count input pass two flip-flops before edge detection.
// [R27]: Compare evaluates once per counter value.
`timescale 1ns/1ps
module counter_array #(
  parameter int MODULES = counter_array_pkg::NUM_MODULES
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Register port
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  // Processor state and interrupt
  input wire logic cpu_idle,
  input wire logic global_irq_enable,
  input wire logic array_irq_enable,
  output logic irq,
  // Timebase sources
  input wire logic timer0_ovf,
  input wire logic external_count_input,
  input wire logic ext_osc,
  // Module lines
  input wire logic [MODULES-1:0] module_line_in,
  output logic [MODULES-1:0] module_line_out,
  output logic [MODULES-1:0] module_line_oe
);

  logic [7:0] ctrl_q;
  logic [7:0] mode_q;
  logic [15:0] cnt_q;
  logic [7:0] snap_q;
  logic [7:0] rdata_q;
  logic eval_q;
  logic wrap_q;
  logic low_wrap_q;
  logic [MODULES+1:0] sync1_q;
  logic [MODULES+1:0] sync2_q;
  logic tick;
  logic active;
  logic adv;
  logic cnt_wr;
  logic step;
  logic [MODULES-1:0] flag_set;
  logic [MODULES-1:0] module_ie;
  logic [7:0] cpm [MODULES];
  logic [15:0] cp [MODULES];
  logic [7:0] rd_mux;

  function automatic logic in_bank(input logic [7:0] addr, input logic [7:0] base);
    return addr >= base && addr < base + 8'(MODULES);
  endfunction

  // ----------------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (reset) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= {ext_osc, external_count_input, module_line_in}; // [R26] [R14]
      sync2_q <= sync1_q;
    end
  end

  counter_timebase u_timebase (
    .core_clk(core_clk),
    .reset(reset),
    .sel(mode_q[counter_array_pkg::MODE_SEL_LSB +: 3]),
    .timer0_ovf(timer0_ovf),
    .count_in_s(sync2_q[MODULES]),
    .osc_s(sync2_q[MODULES+1]),
    .tick(tick)
  );

  // ----------------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------------
  // Idle only suspends when asked; otherwise idle is invisible here.
  assign active = ctrl_q[counter_array_pkg::CTRL_RUN_BIT] && // [R22]
                  !(cpu_idle && mode_q[counter_array_pkg::MODE_IDLE_BIT]); // [R10] [R23]
  assign adv = tick && active;
  assign cnt_wr = sfr_wr && (sfr_addr == counter_array_pkg::ADDR_CNT_L ||
                             sfr_addr == counter_array_pkg::ADDR_CNT_H);
  // A counter write beats a same-cycle tick, so that step neither wraps nor flags.
  assign step = adv && !cnt_wr;

  always_ff @(posedge core_clk) begin
    if (reset) cnt_q <= counter_array_pkg::CNT_RESET;
    else if (sfr_wr && sfr_addr == counter_array_pkg::ADDR_CNT_L) cnt_q[7:0] <= sfr_wdata;
    else if (sfr_wr && sfr_addr == counter_array_pkg::ADDR_CNT_H) cnt_q[15:8] <= sfr_wdata;
    else if (adv) cnt_q <= cnt_q + 16'h0001; // [R3]
  end

  // Modules look at the counter one cycle after it moves, once per value.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      eval_q <= 1'b0;
      wrap_q <= 1'b0;
      low_wrap_q <= 1'b0;
    end else begin
      eval_q <= step; // [R27]
      wrap_q <= step && cnt_q == 16'hFFFF;
      low_wrap_q <= step && cnt_q[7:0] == 8'hFF;
    end
  end

  // ----------------------------------------------------------------------
  // Control, mode and flags
  // ----------------------------------------------------------------------
  // A flag set by hardware in the cycle software writes zero still lands.
  always_ff @(posedge core_clk) begin
    if (reset) ctrl_q <= counter_array_pkg::CTRL_RESET;
    else begin
      if (sfr_wr && sfr_addr == counter_array_pkg::ADDR_CTRL) begin
        ctrl_q[counter_array_pkg::CTRL_RUN_BIT] <= sfr_wdata[counter_array_pkg::CTRL_RUN_BIT];
        ctrl_q[counter_array_pkg::CTRL_OVF_BIT] <= // [R8]
          sfr_wdata[counter_array_pkg::CTRL_OVF_BIT] || (step && cnt_q == 16'hFFFF);
        ctrl_q[MODULES-1:0] <= sfr_wdata[MODULES-1:0] | flag_set;
      end else begin
        if (step && cnt_q == 16'hFFFF) ctrl_q[counter_array_pkg::CTRL_OVF_BIT] <= 1'b1; // [R7]
        ctrl_q[MODULES-1:0] <= ctrl_q[MODULES-1:0] | flag_set; // [R8]
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) mode_q <= counter_array_pkg::MODE_RESET;
    else if (sfr_wr && sfr_addr == counter_array_pkg::ADDR_MODE)
      mode_q <= sfr_wdata & 8'h8F;
  end

  // ----------------------------------------------------------------------
  // Capture/compare modules
  // ----------------------------------------------------------------------
  for (genvar i = 0; i < MODULES; i++) begin : g_cc
    capture_compare_unit u_cc ( // [R1]
      .core_clk(core_clk),
      .reset(reset),
      .mode_wr(sfr_wr && sfr_addr == counter_array_pkg::ADDR_CPM_BASE + 8'(i)),
      .low_wr(sfr_wr && sfr_addr == counter_array_pkg::ADDR_CPL_BASE + 8'(i)),
      .high_wr(sfr_wr && sfr_addr == counter_array_pkg::ADDR_CPH_BASE + 8'(i)),
      .wdata(sfr_wdata),
      .cnt(cnt_q),
      .eval(eval_q),
      .wrap(wrap_q),
      .low_wrap(low_wrap_q),
      .line_s(sync2_q[i]),
      .cpm_q(cpm[i]),
      .cp_q(cp[i]),
      .flag_set(flag_set[i]),
      .line_out_q(module_line_out[i]),
      .line_oe(module_line_oe[i])
    );
    assign module_ie[i] = cpm[i][counter_array_pkg::CPM_IE_BIT];
  end

  // ----------------------------------------------------------------------
  // Interrupt request
  // ----------------------------------------------------------------------
  assign irq = global_irq_enable && array_irq_enable && ( // [R9]
    (ctrl_q[counter_array_pkg::CTRL_OVF_BIT] && mode_q[counter_array_pkg::MODE_OVF_IE_BIT]) ||
    |(ctrl_q[MODULES-1:0] & module_ie)); // [R11]

  // ----------------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------------
  always_comb begin
    rd_mux = 8'h00;
    if (sfr_addr == counter_array_pkg::ADDR_CTRL) rd_mux = ctrl_q;
    else if (sfr_addr == counter_array_pkg::ADDR_MODE) rd_mux = mode_q;
    else if (sfr_addr == counter_array_pkg::ADDR_CNT_L) rd_mux = cnt_q[7:0];
    else if (sfr_addr == counter_array_pkg::ADDR_CNT_H) rd_mux = snap_q; // [R2]
    else begin
      for (int i = 0; i < MODULES; i++) begin
        if (sfr_addr == counter_array_pkg::ADDR_CPM_BASE + 8'(i)) rd_mux = cpm[i];
        if (sfr_addr == counter_array_pkg::ADDR_CPL_BASE + 8'(i)) rd_mux = cp[i][7:0];
        if (sfr_addr == counter_array_pkg::ADDR_CPH_BASE + 8'(i)) rd_mux = cp[i][15:8];
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) snap_q <= 8'h00;
    else if (sfr_rd && sfr_addr == counter_array_pkg::ADDR_CNT_L) snap_q <= cnt_q[15:8]; // [R2]
  end

  always_ff @(posedge core_clk) begin
    if (reset) rdata_q <= 8'h00;
    else if (sfr_rd) rdata_q <= rd_mux;
  end
  assign sfr_rdata = rdata_q;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  overflow_flag_a: assert property (step && cnt_q == 16'hFFFF |=> // [R7]
      ctrl_q[counter_array_pkg::CTRL_OVF_BIT] && cnt_q == 16'h0000)
    else $error("overflow did not set flag");
  flag_sticky_a: assert property (ctrl_q[0] && !(sfr_wr && // [R8]
      sfr_addr == counter_array_pkg::ADDR_CTRL) |=> ctrl_q[0])
    else $error("module flag cleared by hardware");
  irq_gate_a: assert property (irq |-> global_irq_enable && array_irq_enable) // [R9]
    else $error("interrupt without enables");
  irq_mask_a: assert property (global_irq_enable && array_irq_enable && // [R11]
      ctrl_q[0] && module_ie[0] |-> irq)
    else $error("enabled module flag gave no interrupt");
  snapshot_a: assert property (sfr_rd && sfr_addr == counter_array_pkg::ADDR_CNT_L ##1 // [R2]
      sfr_rd && sfr_addr == counter_array_pkg::ADDR_CNT_H |=> sfr_rdata == $past(cnt_q[15:8], 2))
    else $error("high read did not return snapshot");
  read_count_a: assert property (adv && !cnt_wr |=> cnt_q == $past(cnt_q) + 16'h0001) // [R3]
    else $error("counter did not advance");
  hold_stop_a: assert property (!ctrl_q[counter_array_pkg::CTRL_RUN_BIT] && !cnt_wr // [R22]
      |=> $stable(cnt_q))
    else $error("stopped counter moved");
  idle_hold_a: assert property (cpu_idle && mode_q[counter_array_pkg::MODE_IDLE_BIT] && // [R23]
      !cnt_wr |=> $stable(cnt_q))
    else $error("counter moved in idle");
  sysclk_run_a: assert property (active && mode_q[3:1] == 3'b100 && !cnt_wr // [R4]
      |=> cnt_q == $past(cnt_q) + 16'h0001)
    else $error("system clock timebase did not count");
  ecom_clear_a: assert property (sfr_wr && sfr_addr == counter_array_pkg::ADDR_CPL_BASE // [R16]
      |=> !cpm[0][counter_array_pkg::CPM_ECOM_BIT])
    else $error("low compare write left enable set");
  ecom_set_a: assert property (sfr_wr && sfr_addr == counter_array_pkg::ADDR_CPH_BASE // [R16]
      |=> cpm[0][counter_array_pkg::CPM_ECOM_BIT])
    else $error("high compare write left enable clear");

  for (genvar i = 0; i < MODULES; i++) begin : g_chk
    counter_array_pkg::cc_mode_t chk_mode;
    assign chk_mode = counter_array_pkg::mode_of(cpm[i]);
    fast_toggle_a: assert property (chk_mode == counter_array_pkg::MODE_FAST_OUT && // [R18]
        cpm[i][counter_array_pkg::CPM_ECOM_BIT] && eval_q && cnt_q == cp[i]
        |=> module_line_out[i] != $past(module_line_out[i]))
      else $error("fast output line did not toggle");
    pwm_wide_a: assert property (chk_mode == counter_array_pkg::MODE_PWM16 && // [R25]
        wrap_q && cnt_q != cp[i] |=> !module_line_out[i])
      else $error("wide pwm line not low after wrap");
    pwm_reload_a: assert property (chk_mode == counter_array_pkg::MODE_PWM8 && // [R24]
        low_wrap_q && !sfr_wr |=> cp[i][7:0] == $past(cp[i][15:8]))
      else $error("pwm low byte not reloaded");
  end

  capture_seen_c: cover property (flag_set[0] && cpm[0][counter_array_pkg::CPM_RISE_BIT]);
  overflow_seen_c: cover property (wrap_q);
  pwm_high_c: cover property ($rose(module_line_out[0]) && cpm[0][counter_array_pkg::CPM_PWM_BIT]);

endmodule

//--- testbench/line_model.sv
/*
  Board-side model: drives the module lines, the count input and the oscillator.
  Assumes the bench changes want only between clock edges.
*/
`timescale 1ns/1ps
module line_model (
  // Clock
  input wire logic core_clk,
  // Requested line levels
  input wire logic [5:0] want,
  // Pins
  output logic [5:0] line,
  output logic count_in,
  output logic osc
);
  logic [1:0] phase_q = 2'h0;
  initial begin
    line = 6'h00;
    count_in = 1'b1;
    osc = 1'b0;
  end
  // The bench holds each level for many clocks, so every level stands long enough.
  always @(posedge core_clk) line <= want;
  // Three clocks high, three low: never faster than a quarter of the clock.
  always @(posedge core_clk) begin
    phase_q <= (phase_q == 2'h2) ? 2'h0 : phase_q + 2'h1;
    if (phase_q == 2'h2) count_in <= ~count_in;
  end
  // Half the system clock rate, so the oscillator never outruns it.
  always @(negedge core_clk) osc <= ~osc;
endmodule

//--- testbench/programmable_counter_array_test.sv
/*
  Self-checking bench for the counter array, reached through its register port.
  Assumes the package addresses and a one-cycle read answer.
*/
`timescale 1ns/1ps
module programmable_counter_array_test;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] sfr_addr = 8'h00;
  logic sfr_wr = 1'b0;
  logic sfr_rd = 1'b0;
  logic [7:0] sfr_wdata = 8'h00;
  logic [7:0] sfr_rdata;
  logic cpu_idle = 1'b0;
  logic global_irq_enable = 1'b1;
  logic array_irq_enable = 1'b1;
  logic irq;
  logic timer0_ovf = 1'b0;
  logic count_in;
  logic osc;
  logic [5:0] want = 6'h00;
  logic [5:0] line;
  logic [5:0] lo;
  logic [5:0] loe;
  int err_total = 0;
  int cmp_count = 0;
  // Address and reset value; the last row is an unmapped address.
  logic [15:0] rows [0:6] = '{16'hD800, 16'hD900, 16'hDA00, 16'hE000, 16'hE800,
                              16'hF000, 16'h1000};
  // Timebase mode value and the count that a 48-clock window gives.
  logic [15:0] tb_rows [0:4] = '{16'h0004, 16'h020C, 16'h0608, 16'h0A03, 16'h0830};

  always #10 core_clk = ~core_clk;

  counter_array DUT (.core_clk(core_clk), .reset(reset), .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .cpu_idle(cpu_idle), .global_irq_enable(global_irq_enable),
    .array_irq_enable(array_irq_enable), .irq(irq), .timer0_ovf(timer0_ovf),
    .external_count_input(count_in), .ext_osc(osc), .module_line_in(line),
    .module_line_out(lo), .module_line_oe(loe));
  line_model board (.core_clk(core_clk), .want(want), .line(line),
    .count_in(count_in), .osc(osc));

  // --------------------------------------------------------------------
  // Bus and check tasks
  // --------------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    tick(1);
    sfr_wr = 1'b0;
    tick(1);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    sfr_addr = a;
    sfr_rd = 1'b1;
    tick(1);
    sfr_rd = 1'b0;
    tick(1);
    chk(sfr_rdata, e);
  endtask
  task automatic pulse(input int n);
    repeat (n) begin
      timer0_ovf = 1'b1;
      tick(1);
      timer0_ovf = 1'b0;
      tick(1);
    end
  endtask
  task automatic print_verdict;
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // The whole sequence needs well under two thousand clocks.
  initial begin
    #200000;
    err_total++;
    print_verdict();
  end

  initial begin
    tick(2);
    reset = 1'b0;
    foreach (rows[i]) rd(rows[i][15:8], rows[i][7:0]);
    wr(8'hE8, 8'hFE);
    wr(8'hF8, 8'hFF);
    wr(8'hD9, 8'h09);
    wr(8'hD8, 8'h40);
    tick(4);
    rd(8'hD8, 8'hC0);
    chk({7'h00, irq}, 8'h01);
    global_irq_enable = 1'b0;
    tick(1);
    chk({7'h00, irq}, 8'h00);
    rd(8'hD8, 8'hC0);
    wr(8'hD8, 8'h00);
    rd(8'hD8, 8'h00);
    wr(8'hE8, 8'h34);
    wr(8'hF8, 8'h12);
    rd(8'hE8, 8'h34);
    wr(8'hF8, 8'h56);
    rd(8'hF8, 8'h12);
    rd(8'hE8, 8'h34);
    rd(8'hF8, 8'h56);
    // Timer-0 ticks give exact control over every counter step.
    wr(8'hD9, 8'h84);
    wr(8'hE8, 8'hCD);
    wr(8'hD8, 8'h40);
    cpu_idle = 1'b1;
    pulse(3);
    rd(8'hE8, 8'hCD);
    cpu_idle = 1'b0;
    pulse(3);
    rd(8'hE8, 8'hD0);
    wr(8'hDB, 8'h21);
    want = 6'h02;
    tick(6);
    rd(8'hE1, 8'hD0);
    rd(8'hF1, 8'h56);
    rd(8'hD8, 8'h42);
    wr(8'hD8, 8'h40);
    want = 6'h00;
    tick(6);
    rd(8'hD8, 8'h40);
    wr(8'hDA, 8'h49);
    wr(8'hE0, 8'hD2);
    rd(8'hDA, 8'h09);
    wr(8'hF0, 8'h56);
    rd(8'hDA, 8'h49);
    pulse(1);
    rd(8'hD8, 8'h40);
    pulse(1);
    tick(2);
    rd(8'hD8, 8'h41);
    global_irq_enable = 1'b1;
    tick(1);
    chk({7'h00, irq}, 8'h01);
    wr(8'hDA, 8'h48);
    chk({7'h00, irq}, 8'h00);
    rd(8'hD8, 8'h41);
    // Modes on modules 2 to 5, stepped by timer-0 pulses from 56D2.
    wr(8'hDC, 8'h4C);
    wr(8'hE2, 8'hD4);
    wr(8'hF2, 8'h56);
    chk({2'b00, loe}, 8'h04);
    pulse(2);
    chk({2'b00, lo}, 8'h04);
    wr(8'hDD, 8'h46);
    wr(8'hE3, 8'hD6);
    wr(8'hF3, 8'h03);
    pulse(2);
    chk({2'b00, lo}, 8'h0C);
    rd(8'hE3, 8'hD9);
    pulse(3);
    chk({2'b00, lo}, 8'h04);
    wr(8'hE3, 8'hDB);
    wr(8'hF3, 8'h00);
    pulse(257);
    chk({2'b00, lo}, 8'h0C);
    pulse(1);
    chk({2'b00, lo}, 8'h04);
    wr(8'hDE, 8'h42);
    wr(8'hE4, 8'hE0);
    wr(8'hF4, 8'hF0);
    pulse(5);
    chk({2'b00, lo}, 8'h14);
    pulse(32);
    chk({2'b00, lo}, 8'h04);
    rd(8'hE4, 8'hF0);
    wr(8'hE8, 8'hFC);
    wr(8'hF8, 8'hFF);
    wr(8'hDF, 8'hC2);
    wr(8'hE5, 8'hFE);
    wr(8'hF5, 8'hFF);
    pulse(2);
    chk({2'b00, lo}, 8'h24);
    pulse(2);
    chk({2'b00, lo}, 8'h04);
    chk({2'b00, loe}, 8'h3C);
    foreach (tb_rows[i]) begin
      wr(8'hD9, tb_rows[i][15:8]);
      wr(8'hE8, 8'h00);
      tick(47);
      rd(8'hE8, tb_rows[i][7:0]);
    end
    // A mid-run reset must stop the counter and release every line.
    reset = 1'b1;
    tick(2);
    reset = 1'b0;
    rd(8'hE8, 8'h00);
    chk({2'b00, lo | loe}, 8'h00);
    print_verdict();
  end
endmodule
